// ==== shared/dst_pkg.sv ====
// Purpose: Shared constants and types for the diagnostic status and trace bank
// Assumes: Byte-wide attribute values, word-wide for the diagnostic I/O port
// Notes:   Function numbers are kept for reference of the byte slot layout
package dst_pkg;

    // ------------------------------------------------------------------
    // Object classes and attribute numbers
    // ------------------------------------------------------------------
    localparam logic [7:0]  CLASS_STATUS      = 8'h85;   // 133
    localparam logic [7:0]  CLASS_TRACE       = 8'h86;   // 134
    localparam logic [7:0]  ATTR_STAT_BITS    = 8'h01;
    localparam logic [7:0]  ATTR_FIRST_MOD    = 8'h02;
    localparam logic [7:0]  ATTR_DIAG_STAT    = 8'h03;
    localparam logic [7:0]  ATTR_ERR_NUM      = 8'h04;
    localparam logic [7:0]  ATTR_TASK_WORD    = 8'h05;
    localparam logic [7:0]  ATTR_REPLY_WORD   = 8'h06;
    localparam logic [7:0]  ATTR_TR_FIRST     = 8'h01;
    localparam logic [7:0]  ATTR_TR_LAST      = 8'h0B;

    // ------------------------------------------------------------------
    // Function numbers (byte addresses) and trace slot layout
    // ------------------------------------------------------------------
    localparam logic [11:0] FN_STATUS_BITS    = 12'h790;  // 1936
    localparam logic [11:0] FN_FIRST_MODULE   = 12'h791;  // 1937
    localparam logic [11:0] FN_ERROR_NUMBER   = 12'h792;  // 1938
    localparam logic [11:0] FN_TRACE_BASE     = 12'hDA0;  // 3488
    localparam int          TRACE_SLOTS       = 10;       // Byte slots per entry
    localparam logic [3:0]  SLOT_DAYS         = 4'h0;
    localparam logic [3:0]  SLOT_HOURS        = 4'h1;
    localparam logic [3:0]  SLOT_MINUTES      = 4'h2;
    localparam logic [3:0]  SLOT_SECONDS      = 4'h3;
    localparam logic [3:0]  SLOT_CENTI        = 4'h4;
    localparam logic [3:0]  SLOT_MOD_KIND     = 4'h5;
    localparam logic [3:0]  SLOT_MOD_POS      = 4'h6;
    localparam logic [3:0]  SLOT_CHANNEL      = 4'h7;
    localparam logic [3:0]  SLOT_ERR_NUM      = 4'h8;
    localparam logic [3:0]  SLOT_FOLLOWING    = 4'h9;
    localparam int          FIRST_FLAG_BIT    = 7;        // In slot 4
    localparam int          CHANNEL_BITS      = 6;        // Slot 7 bits 0..5
    localparam int          CENTI_BITS        = 7;        // Slot 4 bits 0..6
    localparam logic [7:0]  POS_NOT_MODULE    = 8'h3F;    // 63

    // ------------------------------------------------------------------
    // Status byte field positions
    // ------------------------------------------------------------------
    localparam int          SRC_VALVE_BIT     = 0;
    localparam int          SRC_OUTPUT_BIT    = 1;
    localparam int          SRC_INPUT_BIT     = 2;
    localparam int          SRC_ANALOG_BIT    = 3;
    localparam int          TYP_UNDERVOLT_BIT = 4;
    localparam int          TYP_SHORT_BIT     = 5;
    localparam int          TYP_WIREBRK_BIT   = 6;
    localparam int          TYP_OTHER_BIT     = 7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ            = 10_000_000;
    localparam int          TICK_MS           = 10;
    localparam int          TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
    localparam logic [6:0]  CENTI_WRAP        = 7'h63;    // 99
    localparam logic [7:0]  SEC_WRAP          = 8'h3B;    // 59
    localparam logic [7:0]  MIN_WRAP          = 8'h3B;    // 59
    localparam logic [7:0]  HOUR_WRAP         = 8'h17;    // 23
    localparam logic [7:0]  ZERO_BYTE         = 8'h00;
    localparam logic [15:0] ZERO_WORD         = 16'h0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] err_type;    // Bits 7..4: other, wire break, short, undervoltage
        logic [3:0] err_source;  // Bits 3..0: analogue, input, output, valve
    } dst_status_t;

    typedef struct packed {
        logic [7:0] days;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
        logic [6:0] centi;
    } dst_time_t;

    typedef struct packed {
        logic [7:0] mod_kind;
        logic [7:0] mod_pos;
        logic [5:0] channel;
        logic [7:0] err_num;
        logic [7:0] following;
    } dst_event_t;

    typedef struct packed {
        logic       first;
        dst_time_t  stamp;
        dst_event_t evt;
    } dst_entry_t;

    typedef struct packed {
        logic        set;        // 1 = Set, 0 = Get
        logic [7:0]  cls;
        logic [7:0]  inst;
        logic [7:0]  attr;
        logic [15:0] wdata;
    } dst_req_t;

    typedef struct packed {
        logic        ok;         // 0 = refused
        logic [15:0] data;
    } dst_resp_t;

endpackage : dst_pkg

// ==== verilog/dst_bank.sv ====
// Purpose: Diagnostic status byte, diagnostic I/O task/reply window and
//          40-entry diagnostic trace memory, reached by attribute Get/Set
// Assumes: Status, reply word and events come from logic on clk_in
// Notes:   Trace is a ring; index 0 always reads the newest entry
//
// Behaviour
// - Status byte low nibble: bit0 valve, bit1 output, bit2 input, bit3 analogue.
// - Status byte high nibble: undervoltage, short/overload, wire break, other error.
// - Read-only first faulty module, error number and diagnostic status bytes.
// - Master writes 16-bit task word; device holds, returns and drives it out.
// - The 16 reply bits of the diagnostic port read back as a word.
// - Up to 40 trace entries, one per event, each a separate record.
// - Events indexed 0 to 39, index 0 newest, older ones move up.
// - Entry bytes sit at slot ten times index plus field, base 3488.
// - Slot 4 bit 7 is set only in the first entry after power-on.
// - Days, hours, minutes, seconds since power-on stamp slots 0 to 3.
// - Slot 4 bits 0..6 hold the count of 10 ms units.
// - Module code and position stored; position 63 means no module.
// - First faulty channel kept in slot 7 bits 0 to 5.
// - Count of further channels with the same error is stored.
// - Error number stored as one byte in slot 8.
// - Error number zero forces module code, channel and following to zero.
`timescale 1ns/10ps
`default_nettype none

module dst_bank
    import dst_pkg::*;
#(
    parameter int DEPTH        = 40,
    parameter int TICK_COUNT   = TICK_CYCLES
)(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Node status from the fieldbus node core
    input  wire dst_status_t status_in,
    input  wire logic [7:0]  first_module_in,
    input  wire logic [7:0]  error_number_in,
    input  wire logic [7:0]  diag_status_in,
    // Diagnostic I/O interface
    output logic [15:0]      task_word_out,
    input  wire logic [15:0] reply_word_in,
    // Diagnostic events to record
    input  wire logic        evt_valid_in,
    input  wire dst_event_t  evt_in,
    // Attribute access from the fieldbus master
    input  wire logic        req_valid_in,
    input  wire dst_req_t    req_in,
    output logic             resp_valid_out,
    output dst_resp_t        resp_out,
    output logic [7:0]       entry_count_out
);

    localparam int PW = $clog2(DEPTH);
    localparam int TW = $clog2(TICK_COUNT + 1);
    localparam logic [PW-1:0] PTR_LAST  = PW'(DEPTH - 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_COUNT - 1);

    // ------------------------------------------------------------------
    // Slot byte of an entry: slot = 10 * index + field
    // ------------------------------------------------------------------
    function automatic logic [7:0] slot_byte(input dst_entry_t e, input logic [3:0] field);
        logic [7:0] b;
        b = ZERO_BYTE;
        unique case (field)
            SLOT_DAYS:      b = e.stamp.days;
            SLOT_HOURS:     b = e.stamp.hours;
            SLOT_MINUTES:   b = e.stamp.minutes;
            SLOT_SECONDS:   b = e.stamp.seconds;
            SLOT_CENTI:     b = {e.first, e.stamp.centi};
            SLOT_MOD_KIND:  b = e.evt.mod_kind;
            SLOT_MOD_POS:   b = e.evt.mod_pos;
            SLOT_CHANNEL:   b = {2'b00, e.evt.channel};
            SLOT_ERR_NUM:   b = e.evt.err_num;
            SLOT_FOLLOWING: b = e.evt.following;
            default:        b = ZERO_BYTE;
        endcase
        return b;
    endfunction : slot_byte

    // Attribute 1 is slot 4 bit 7, attributes 2..11 are slots 0..9 in order
    function automatic logic [3:0] attr_field(input logic [7:0] attr);
        logic [3:0] f;
        f = SLOT_DAYS;
        if (attr == ATTR_TR_FIRST)
            f = SLOT_CENTI;
        else
            f = 4'(attr - 8'h02);
        return f;
    endfunction : attr_field

    // ------------------------------------------------------------------
    // Elapsed time since power-on
    // ------------------------------------------------------------------
    logic [TW-1:0] tick_cnt_q;
    logic          tick_q;
    dst_time_t     now_q;

    // 10 ms enable from the cycle divider
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            if (tick_cnt_q == TICK_LAST)
                tick_cnt_q <= '0;
            else
                tick_cnt_q <= tick_cnt_q + TW'(1);
        end
    end

    // Centiseconds, seconds, minutes, hours, days; days wrap at 255
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            now_q <= '0;
        end
        else if (tick_q)
        begin
            if (now_q.centi != CENTI_WRAP)
                now_q.centi <= now_q.centi + 7'h01;
            else
            begin
                now_q.centi <= '0;
                if (now_q.seconds != SEC_WRAP)
                    now_q.seconds <= now_q.seconds + 8'h01;
                else
                begin
                    now_q.seconds <= ZERO_BYTE;
                    if (now_q.minutes != MIN_WRAP)
                        now_q.minutes <= now_q.minutes + 8'h01;
                    else
                    begin
                        now_q.minutes <= ZERO_BYTE;
                        if (now_q.hours != HOUR_WRAP)
                            now_q.hours <= now_q.hours + 8'h01;
                        else
                        begin
                            now_q.hours <= ZERO_BYTE;
                            now_q.days  <= now_q.days + 8'h01;
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Trace ring: newest_q points at index 0, older entries follow
    // ------------------------------------------------------------------
    dst_entry_t    trace_mem [DEPTH];
    logic [PW-1:0] newest_q;
    logic [7:0]    count_q;
    logic          first_pending_q;
    logic [PW-1:0] wr_slot;
    dst_entry_t    new_entry;

    // Next ring slot sits one below the newest, so all indices shift up by one
    assign wr_slot = (newest_q == '0) ? PTR_LAST : newest_q - PW'(1);

    // Build the entry; error number zero clears the dependent fields
    always_comb
    begin
        new_entry             = '0;
        new_entry.first       = first_pending_q;
        new_entry.stamp       = now_q;
        new_entry.evt         = evt_in;
        if (evt_in.err_num == ZERO_BYTE)
        begin
            new_entry.evt.mod_kind  = ZERO_BYTE;
            new_entry.evt.channel   = '0;
            new_entry.evt.following = ZERO_BYTE;
        end
    end

    // Store the event; the oldest is overwritten once the ring is full
    always_ff @(posedge clk_in)
    begin
        if (!rst_in && evt_valid_in)
            trace_mem[wr_slot] <= new_entry;
    end

    // Ring pointer and number of valid entries
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            newest_q <= '0;
            count_q  <= ZERO_BYTE;
        end
        else if (evt_valid_in)
        begin
            newest_q <= wr_slot;
            if (count_q != 8'(DEPTH))
                count_q <= count_q + 8'h01;
        end
    end

    // First-entry mark: armed by reset, spent by the first record
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            first_pending_q <= 1'b1;
        else if (evt_valid_in)
            first_pending_q <= 1'b0;
    end

    assign entry_count_out = count_q;

    // ------------------------------------------------------------------
    // Task word held for the diagnostic I/O interface
    // ------------------------------------------------------------------
    logic [15:0] task_q;
    logic        task_wr;

    assign task_wr = req_valid_in && req_in.set && (req_in.cls == CLASS_STATUS)
                     && (req_in.inst == 8'h01) && (req_in.attr == ATTR_TASK_WORD);

    // Set on attribute 5 updates the task bits
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            task_q <= ZERO_WORD;
        else if (task_wr)
            task_q <= req_in.wdata;
    end

    assign task_word_out = task_q;

    // ------------------------------------------------------------------
    // Attribute decode
    // ------------------------------------------------------------------
    dst_resp_t     resp_d;
    logic [7:0]    d_idx;
    logic [PW-1:0] phys;

    assign d_idx = req_in.inst - 8'h01;
    assign phys  = PW'((32'(newest_q) + 32'(d_idx)) % DEPTH);

    // Answer: unknown class, instance or attribute, or Set on Get-only, is refused
    always_comb
    begin
        resp_d = '0;
        if (req_in.cls == CLASS_STATUS && req_in.inst == 8'h01)
        begin
            resp_d.ok = !req_in.set || (req_in.attr == ATTR_TASK_WORD);
            unique case (req_in.attr)
                ATTR_STAT_BITS:  resp_d.data = {8'h00, status_in};
                ATTR_FIRST_MOD:  resp_d.data = {8'h00, first_module_in};
                ATTR_DIAG_STAT:  resp_d.data = {8'h00, diag_status_in};
                ATTR_ERR_NUM:    resp_d.data = {8'h00, error_number_in};
                ATTR_TASK_WORD:  resp_d.data = req_in.set ? req_in.wdata : task_q;
                ATTR_REPLY_WORD: resp_d.data = reply_word_in;
                default:         resp_d.ok   = 1'b0;
            endcase
        end
        else if (req_in.cls == CLASS_TRACE && !req_in.set && req_in.inst != ZERO_BYTE
                 && req_in.inst <= count_q && req_in.attr >= ATTR_TR_FIRST
                 && req_in.attr <= ATTR_TR_LAST)
        begin
            resp_d.ok = 1'b1;
            if (req_in.attr == ATTR_TR_FIRST)
                resp_d.data = {15'h0000, trace_mem[phys].first};
            else
                resp_d.data = {8'h00, slot_byte(trace_mem[phys], attr_field(req_in.attr))};
        end
    end

    // Registered answer one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            resp_valid_out <= 1'b0;
            resp_out       <= '0;
        end
        else
        begin
            resp_valid_out <= req_valid_in;
            if (req_valid_in)
                resp_out <= resp_d;
        end
    end

endmodule : dst_bank

`default_nettype wire

// ==== tb/dst_diag_port_model.sv ====
// Purpose: Behavioural diagnostic I/O port facing the bank
// Assumes: Reply is the inverted task word, one cycle later
// Notes:   Inversion makes a stale or stuck reply visible
`timescale 1ns/10ps
`default_nettype none

module dst_diag_port_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] task_word_in,
    output logic [15:0]      reply_word_out
);
    // Answer each task word with its complement
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            reply_word_out <= 16'hFFFF;
        else
            reply_word_out <= ~task_word_in;
    end
endmodule : dst_diag_port_model

`default_nettype wire

// ==== tb/dst_bank_monitor.sv ====
// Purpose: Port-level checks of the diagnostic status and trace bank
// Assumes: One clock domain, asynchronous reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/10ps
`default_nettype none

module dst_bank_monitor
    import dst_pkg::*;
#(
    parameter int DEPTH = 40
)(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire dst_status_t status_in,
    input wire logic [7:0]  first_module_in,
    input wire logic [15:0] reply_word_in,
    input wire logic        evt_valid_in,
    input wire logic        req_valid_in,
    input wire dst_req_t    req_in,
    input wire logic        resp_valid_out,
    input wire dst_resp_t   resp_out,
    input wire logic [15:0] task_word_out,
    input wire logic [7:0]  entry_count_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Get on the status object, instance 1
    logic g133;
    assign g133 = req_valid_in && !req_in.set && req_in.cls == CLASS_STATUS && req_in.inst == 8'h01;

    property p_resp; req_valid_in |=> resp_valid_out; endproperty
    a_resp: assert property (p_resp) else $error("no answer after request");
    property p_quiet; !req_valid_in |=> !resp_valid_out; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_status; g133 && req_in.attr == ATTR_STAT_BITS
        |=> resp_out.ok && resp_out.data == {8'h00, $past(status_in)}; endproperty
    a_status: assert property (p_status) else $error("status byte wrong");
    property p_first; g133 && req_in.attr == ATTR_FIRST_MOD
        |=> resp_out.data == {8'h00, $past(first_module_in)}; endproperty
    a_first: assert property (p_first) else $error("first module wrong");
    property p_reply; g133 && req_in.attr == ATTR_REPLY_WORD |=> resp_out.data == $past(reply_word_in); endproperty
    a_reply: assert property (p_reply) else $error("reply word wrong");
    property p_task; req_valid_in && req_in.set && req_in.cls == CLASS_STATUS && req_in.inst == 8'h01
        && req_in.attr == ATTR_TASK_WORD |=> task_word_out == $past(req_in.wdata); endproperty
    a_task: assert property (p_task) else $error("task word not written");
    property p_hold; !(req_valid_in && req_in.set) |=> $stable(task_word_out); endproperty
    a_hold: assert property (p_hold) else $error("task word changed");
    property p_count; evt_valid_in && entry_count_out < DEPTH
        |=> entry_count_out == $past(entry_count_out) + 8'h01; endproperty
    a_count: assert property (p_count) else $error("entry count not advanced");
    property p_cstay; !evt_valid_in |=> $stable(entry_count_out); endproperty
    a_cstay: assert property (p_cstay) else $error("entry count moved");
    property p_cmax; entry_count_out <= DEPTH; endproperty
    a_cmax: assert property (p_cmax) else $error("entry count above depth");
    property p_range; req_valid_in && req_in.cls == CLASS_TRACE
        && (req_in.inst == 8'h00 || req_in.inst > entry_count_out) |=> !resp_out.ok; endproperty
    a_range: assert property (p_range) else $error("absent entry answered");

    // Main scenarios
    c_trace: cover property (req_valid_in && req_in.cls == CLASS_TRACE ##1 resp_out.ok);
    c_full: cover property (entry_count_out == DEPTH);
    c_task: cover property (req_valid_in && req_in.set ##1 resp_out.ok);
endmodule : dst_bank_monitor

bind dst_bank dst_bank_monitor #(.DEPTH(DEPTH)) u_mon (.clk_in(clk_in), .rst_in(rst_in),
    .status_in(status_in), .first_module_in(first_module_in), .reply_word_in(reply_word_in),
    .evt_valid_in(evt_valid_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .resp_valid_out(resp_valid_out), .resp_out(resp_out), .task_word_out(task_word_out),
    .entry_count_out(entry_count_out));

`default_nettype wire

// ==== tb/dst_bank_test.sv ====
// Purpose: Self-checking bench for the diagnostic status and trace bank
// Assumes: Inputs change on the falling edge; tick shortened to 10 cycles
// Notes:   Answers are sampled at the falling edge after the taking edge
`timescale 1ns/10ps
`default_nettype none

module dst_bank_test;
    import dst_pkg::*;
    localparam int TICK  = 10;
    localparam int LIMIT = 6000;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    dst_status_t status_in = '0;
    logic [7:0]  first_module_in = 8'h00;
    logic [7:0]  error_number_in = 8'h00;
    logic [7:0]  diag_status_in = 8'h00;
    logic [15:0] task_word_out;
    logic [15:0] reply_word_in;
    logic        evt_valid_in = 1'b0;
    dst_event_t  evt_in = '0;
    logic        req_valid_in = 1'b0;
    dst_req_t    req_in = '0;
    logic        resp_valid_out;
    dst_resp_t   resp_out;
    logic [7:0]  entry_count_out;
    dst_resp_t   r;
    dst_event_t  e1;
    dst_event_t  e2;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int t_rel = 0;
    int t_ev = 0;
    int ec = 0;

    always #50 clk_in = ~clk_in;

    dst_bank #(.DEPTH(40), .TICK_COUNT(TICK)) uut (.clk_in(clk_in), .rst_in(rst_in), .status_in(status_in),
        .first_module_in(first_module_in), .error_number_in(error_number_in), .diag_status_in(diag_status_in),
        .task_word_out(task_word_out), .reply_word_in(reply_word_in), .evt_valid_in(evt_valid_in),
        .evt_in(evt_in), .req_valid_in(req_valid_in), .req_in(req_in), .resp_valid_out(resp_valid_out),
        .resp_out(resp_out), .entry_count_out(entry_count_out));

    dst_diag_port_model u_port (.clk_in(clk_in), .rst_in(rst_in), .task_word_in(task_word_out),
        .reply_word_out(reply_word_in));

    task conclude;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Cycle count and hang guard
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            $display("unexpected timeout: expected %0d seen %0d", LIMIT - 1, cyc);
            conclude();
        end
    end

    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One request, answer taken one cycle later, then one idle cycle
    task acc(input logic s, input logic [7:0] c, input logic [7:0] i, input logic [7:0] a, input logic [15:0] w);
        req_in = '{set: s, cls: c, inst: i, attr: a, wdata: w};
        req_valid_in = 1'b1;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        r = resp_out;
        chk("resp_valid", 16'h0001, {15'h0000, resp_valid_out});
        @(negedge clk_in);
    endtask : acc

    task get(input logic [7:0] c, input logic [7:0] i, input logic [7:0] a, input logic [15:0] exp, input string nm);
        acc(1'b0, c, i, a, 16'h0000);
        chk(nm, exp, r.data);
        chk("ok", 16'h0001, {15'h0000, r.ok});
    endtask : get

    task refused(input logic s, input logic [7:0] c, input logic [7:0] i, input logic [7:0] a);
        acc(s, c, i, a, 16'h5A5A);
        chk("refused_ok", 16'h0000, {15'h0000, r.ok});
    endtask : refused

    task ev(input dst_event_t e);
        evt_in = e;
        evt_valid_in = 1'b1;
        @(negedge clk_in);
        evt_valid_in = 1'b0;
        @(negedge clk_in);
    endtask : ev

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        t_rel = cyc;
        chk("task_word", ZERO_WORD, task_word_out);
        chk("count", 16'h0000, {8'h00, entry_count_out});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin status_in = dst_status_t'(8'h01 << i); get(CLASS_STATUS, 8'h01,
            ATTR_STAT_BITS, {8'h00, 8'h01 << i}, "status"); end
        first_module_in = 8'h07;
        error_number_in = 8'hC5;
        diag_status_in = 8'h3C;
        get(CLASS_STATUS, 8'h01, ATTR_FIRST_MOD, 16'h0007, "first_module");
        get(CLASS_STATUS, 8'h01, ATTR_DIAG_STAT, 16'h003C, "diag_status");
        get(CLASS_STATUS, 8'h01, ATTR_ERR_NUM, 16'h00C5, "error_number");
        refused(1'b1, CLASS_STATUS, 8'h01, ATTR_ERR_NUM);
        refused(1'b0, 8'h80, 8'h01, 8'h01);
        refused(1'b0, CLASS_STATUS, 8'h02, ATTR_STAT_BITS);
        $display("test status done");
        acc(1'b1, CLASS_STATUS, 8'h01, ATTR_TASK_WORD, 16'hA5C3);
        chk("task_word", 16'hA5C3, task_word_out);
        get(CLASS_STATUS, 8'h01, ATTR_TASK_WORD, 16'hA5C3, "task_readback");
        get(CLASS_STATUS, 8'h01, ATTR_REPLY_WORD, 16'h5A3C, "reply_word");
        refused(1'b1, CLASS_STATUS, 8'h01, ATTR_REPLY_WORD);
        refused(1'b1, CLASS_STATUS, 8'h02, ATTR_TASK_WORD);
        chk("task_word", 16'hA5C3, task_word_out);
        $display("test port done");
        refused(1'b0, CLASS_TRACE, 8'h01, ATTR_TR_FIRST);
        while (cyc - t_rel < 1250) @(negedge clk_in);
        e1 = '{mod_kind: 8'h21, mod_pos: POS_NOT_MODULE, channel: 6'h2A, err_num: 8'h12, following: 8'h03};
        e2 = '{mod_kind: 8'h44, mod_pos: 8'h05, channel: 6'h11, err_num: 8'h00, following: 8'h09};
        t_ev = cyc + 1;
        ev(e1);
        ev(e2);
        chk("count", 16'h0002, {8'h00, entry_count_out});
        get(CLASS_TRACE, 8'h01, 8'h07, 16'h0000, "kind_zero");
        get(CLASS_TRACE, 8'h01, 8'h08, 16'h0005, "position");
        get(CLASS_TRACE, 8'h01, 8'h09, 16'h0000, "channel_zero");
        get(CLASS_TRACE, 8'h01, 8'h0B, 16'h0000, "following_zero");
        get(CLASS_TRACE, 8'h01, 8'h01, 16'h0000, "first_newer");
        get(CLASS_TRACE, 8'h02, 8'h01, 16'h0001, "first_older");
        get(CLASS_TRACE, 8'h02, 8'h07, 16'h0021, "kind");
        get(CLASS_TRACE, 8'h02, 8'h08, 16'h003F, "position_63");
        get(CLASS_TRACE, 8'h02, 8'h09, 16'h002A, "channel");
        get(CLASS_TRACE, 8'h02, 8'h0A, 16'h0012, "error");
        get(CLASS_TRACE, 8'h02, 8'h0B, 16'h0003, "following");
        for (int a = 2; a < 5; a++) get(CLASS_TRACE, 8'h02, 8'(a), 16'h0000, "day_hour_min");
        get(CLASS_TRACE, 8'h02, 8'h05, 16'((t_ev - t_rel) / 1000), "seconds");
        acc(1'b0, CLASS_TRACE, 8'h02, 8'h06, 16'h0000);
        chk("first_bit", 16'h0001, {15'h0000, r.data[7]});
        ec = ((t_ev - t_rel) / TICK) % 100;
        total_checks++;
        if ((r.data[6:0] + 1 >= ec && r.data[6:0] <= ec + 1) !== 1'b1)
        begin
            err_total++;
            $display("unexpected centi: expected %0d seen %0d", ec, r.data[6:0]);
        end
        refused(1'b1, CLASS_TRACE, 8'h01, 8'h01);
        refused(1'b0, CLASS_TRACE, 8'h03, 8'h01);
        refused(1'b0, CLASS_TRACE, 8'h00, 8'h01);
        refused(1'b0, CLASS_TRACE, 8'h01, 8'h0C);
        $display("test trace done");
        for (int i = 1; i <= 40; i++) begin e1.err_num = 8'(i); ev(e1); end
        chk("count", 16'h0028, {8'h00, entry_count_out});
        get(CLASS_TRACE, 8'h01, 8'h0A, 16'h0028, "newest");
        get(CLASS_TRACE, 8'h28, 8'h0A, 16'h0001, "oldest");
        refused(1'b0, CLASS_TRACE, 8'h29, 8'h01);
        $display("test fill done");
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        chk("count", 16'h0000, {8'h00, entry_count_out});
        chk("task_word", ZERO_WORD, task_word_out);
        ev(e2);
        get(CLASS_TRACE, 8'h01, 8'h01, 16'h0001, "first_again");
        e2.err_num = 8'h90;
        ev(e2);
        get(CLASS_TRACE, 8'h01, 8'h01, 16'h0000, "first_spent");
        get(CLASS_TRACE, 8'h01, 8'h0A, 16'h0090, "service_error");
        $display("test rereset done");
        conclude();
    end
endmodule : dst_bank_test

`default_nettype wire
